// ---- logic/adcsc_pkg.sv ----
// package: register map, field positions and types of the converter control block
package adcsc_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [3:0] CTRL_ONE_OFS  = 4'h0;
  localparam logic [3:0] CTRL_FOUR_OFS = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS  = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS  = 4'hC;

  // ----------------------------------------
  // control one field positions
  // ----------------------------------------
  localparam int SEL_POS    = 5;
  localparam int GROUP_POS  = 4;
  localparam int SIMUL_POS  = 3;
  localparam int AUTO_POS   = 2;
  localparam int SAMPLE_POS = 1;
  localparam int DONE_POS   = 0;
  localparam int TWELVE_POS = 10;
  localparam int CHCNT_POS  = 8;

  // ----------------------------------------
  // control four field positions
  // ----------------------------------------
  localparam int DMAEN_POS = 8;
  localparam int DMABL_POS = 0;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [15:0] CTRL_ONE_RST  = 16'h0000;
  localparam logic [15:0] CTRL_FOUR_RST = 16'h0000;
  localparam int          CONV_NS       = 48;
  localparam int          CLK_MHZ       = 250;
  localparam int          CONV_CYC      = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int          AUTO_NS       = 12;
  localparam int          AUTO_CYC      = (AUTO_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // trigger inputs travelling together
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] pwmGenPrimary;
    logic [3:0] trigGenOut;
    logic       timer5Compare;
    logic       timer3Compare;
    logic       pwmSecSpecial;
    logic       pwmPriSpecial;
    logic       chargeTimeUnit;
  } adcsc_trig_type;

  typedef struct packed {
    logic       dmaEnable;
    logic [7:0] wordsPerInput;
    logic [3:0] chanSampleMask;
    logic       simultaneous;
  } adcsc_cfg_type;

  typedef enum logic [1:0] {
    IDLE,
    SAMPLING,
    CONVERTING
  } adcsc_state_type;

endpackage

// ---- logic/adcsc_top.sv ----
// converter sample and conversion control with wishbone registers
`timescale 1ns/1ps

module adcsc_top #(
  parameter int CONV_CYCLES = adcsc_pkg::CONV_CYC,
  parameter int AUTO_CYCLES = adcsc_pkg::AUTO_CYC
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [3:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          wb_err_o,
  // on-chip trigger sources and the external pin
  input  wire adcsc_pkg::adcsc_trig_type trigIn,
  input  wire logic                     externalInterruptPinZero,
  // converter side
  output logic                          convStart,
  output logic                          sampleActive,
  output logic                          convDoneEvent,
  output adcsc_pkg::adcsc_cfg_type      cfgOut,
  // interrupt
  output logic                          irq
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rstSync1Q, rstSyncQ;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1Q <= 1'b0;
      rstSyncQ  <= 1'b0;
    end else begin
      rstSync1Q <= 1'b1;
      rstSyncQ  <= rstSync1Q;
    end
  end
  wire logic rstN = rstSyncQ;

  // ----------------------------------------
  // pin synchroniser and edge
  // ----------------------------------------
  logic pinMetaQ, pinSyncQ, pinPrevQ;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pinMetaQ <= 1'b0;
      pinSyncQ <= 1'b0;
      pinPrevQ <= 1'b0;
    end else begin
      pinMetaQ <= externalInterruptPinZero;
      pinSyncQ <= pinMetaQ;
      pinPrevQ <= pinSyncQ;
    end
  end
  // rising edge taken as the active transition
  wire logic pinEdge = pinSyncQ & ~pinPrevQ;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] ctrlOneQ, ctrlFourQ;
  logic        sampleQ, doneQ, irqStatQ, irqMaskQ;
  adcsc_pkg::adcsc_state_type stateQ;
  logic [15:0] cntQ;

  wire logic [2:0] triggerSelect = ctrlOneQ[adcsc_pkg::SEL_POS +: 3];
  wire logic       triggerGroup  = ctrlOneQ[adcsc_pkg::GROUP_POS];
  wire logic       autoStart     = ctrlOneQ[adcsc_pkg::AUTO_POS];
  wire logic       twelveBit     = ctrlOneQ[adcsc_pkg::TWELVE_POS];
  wire logic [1:0] chanCount     = ctrlOneQ[adcsc_pkg::CHCNT_POS +: 2];
  // simultaneous bit does not exist in twelve bit mode
  wire logic       simulSample   = ctrlOneQ[adcsc_pkg::SIMUL_POS] & ~twelveBit;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire logic selOne   = wb_adr_i == adcsc_pkg::CTRL_ONE_OFS;
  wire logic selFour  = wb_adr_i == adcsc_pkg::CTRL_FOUR_OFS;
  wire logic selStat  = wb_adr_i == adcsc_pkg::IRQ_STAT_OFS;
  wire logic selMask  = wb_adr_i == adcsc_pkg::IRQ_MASK_OFS;
  wire logic mapped   = selOne | selFour | selStat | selMask;
  wire logic wrLow    = busReq & wb_we_i & wb_sel_i[0];
  wire logic wrHigh   = busReq & wb_we_i & wb_sel_i[1];
  wire logic wrOneLo  = wrLow & selOne;
  wire logic wrOneHi  = wrHigh & selOne;
  wire logic wrFourLo = wrLow & selFour;
  wire logic wrFourHi = wrHigh & selFour;

  // software sample writes
  wire logic swSampleSet = wrOneLo & wb_dat_i[adcsc_pkg::SAMPLE_POS] & ~autoStart;
  wire logic swSampleClr = wrOneLo & ~wb_dat_i[adcsc_pkg::SAMPLE_POS] & sampleQ;
  // only a zero write clears the done flag; a one is ignored
  wire logic swDoneClr   = wrOneLo & ~wb_dat_i[adcsc_pkg::DONE_POS];

  // ----------------------------------------
  // trigger selection
  // ----------------------------------------
  // at or past the count, so a switch to this source in mid-sampling never waits for a wrap
  wire logic autoCount = (cntQ >= 16'(AUTO_CYCLES - 1));
  logic selEvent;
  always_comb begin
    selEvent = 1'b0;
    if (triggerGroup) begin
      case (triggerSelect)
        3'h0, 3'h1, 3'h2: selEvent = trigIn.pwmGenPrimary[triggerSelect[1:0]];
        3'h3: selEvent = trigIn.trigGenOut[0];
        3'h4: selEvent = trigIn.trigGenOut[1];
        3'h5: selEvent = trigIn.trigGenOut[2];
        3'h6: selEvent = trigIn.trigGenOut[3];
        default: selEvent = 1'b0; // reserved code never triggers
      endcase
    end else begin
      case (triggerSelect)
        3'h0: selEvent = swSampleClr;
        3'h1: selEvent = pinEdge;
        3'h2: selEvent = trigIn.timer3Compare;
        3'h3: selEvent = trigIn.pwmPriSpecial;
        3'h4: selEvent = trigIn.timer5Compare;
        3'h5: selEvent = trigIn.pwmSecSpecial;
        3'h6: selEvent = trigIn.chargeTimeUnit;
        default: selEvent = autoCount;
      endcase
    end
  end

  // ----------------------------------------
  // sample / convert sequencing
  // ----------------------------------------
  wire logic startConv = (stateQ == adcsc_pkg::SAMPLING) & selEvent;
  wire logic convEnd   = (stateQ == adcsc_pkg::CONVERTING) & (cntQ == 16'(CONV_CYCLES - 1));
  adcsc_pkg::adcsc_state_type stateD;
  always_comb begin
    case (stateQ)
      adcsc_pkg::IDLE:       stateD = (swSampleSet | autoStart) ? adcsc_pkg::SAMPLING : adcsc_pkg::IDLE;
      adcsc_pkg::SAMPLING:   stateD = startConv ? adcsc_pkg::CONVERTING : adcsc_pkg::SAMPLING;
      adcsc_pkg::CONVERTING: begin
        if (convEnd) begin
          stateD = autoStart ? adcsc_pkg::SAMPLING : adcsc_pkg::IDLE;
        end else begin
          stateD = adcsc_pkg::CONVERTING;
        end
      end
      default:               stateD = adcsc_pkg::IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      stateQ <= adcsc_pkg::IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // one counter times both phases, restarted on every state change
  wire logic [15:0] cntD = (stateD != stateQ) ? 16'h0000 : cntQ + 16'h0001;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      cntQ <= 16'h0000;
    end else begin
      cntQ <= cntD;
    end
  end

  // sample bit mirrors the sampling state
  always_comb sampleQ = (stateQ == adcsc_pkg::SAMPLING);

  // ----------------------------------------
  // done flag: hardware end wins over software clear
  // ----------------------------------------
  wire logic doneSet = convEnd;
  // a software clear only drops the flag, the conversion runs on
  wire logic doneClr = startConv | swDoneClr;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      doneQ <= 1'b0;
    end else if (doneSet) begin
      doneQ <= 1'b1;
    end else if (doneClr) begin
      doneQ <= 1'b0;
    end
  end

  // ----------------------------------------
  // control register storage
  // ----------------------------------------
  // sample and done bits live outside the stored word
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ctrlOneQ <= adcsc_pkg::CTRL_ONE_RST;
    end else begin
      if (wrOneLo) begin
        ctrlOneQ[7:2] <= wb_dat_i[7:2];
      end
      if (wrOneHi) begin
        ctrlOneQ[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // unimplemented bits of control four never leave their reset value
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ctrlFourQ <= adcsc_pkg::CTRL_FOUR_RST;
    end else begin
      if (wrFourLo) begin
        ctrlFourQ[2:0] <= wb_dat_i[2:0];
      end
      if (wrFourHi) begin
        ctrlFourQ[8] <= wb_dat_i[8];
      end
    end
  end

  wire logic wrMask = wrLow & selMask;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      irqMaskQ <= 1'b0;
    end else if (wrMask) begin
      irqMaskQ <= wb_dat_i[0];
    end
  end

  // ----------------------------------------
  // interrupt status, write one to clear, set wins
  // ----------------------------------------
  always_comb convDoneEvent = convEnd;
  wire logic statClr = wrLow & selStat & wb_dat_i[0];
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      irqStatQ <= 1'b0;
    end else if (convDoneEvent) begin
      irqStatQ <= 1'b1;
    end else if (statClr) begin
      irqStatQ <= 1'b0;
    end
  end
  always_comb irq = irqStatQ & irqMaskQ;

  // ----------------------------------------
  // read data and acknowledge
  // ----------------------------------------
  logic [15:0] rdOne;
  always_comb begin
    rdOne = ctrlOneQ & 16'h07FC;
    rdOne[adcsc_pkg::SIMUL_POS]  = simulSample;
    rdOne[adcsc_pkg::SAMPLE_POS] = sampleQ;
    rdOne[adcsc_pkg::DONE_POS]   = doneQ;
  end
  wire logic [15:0] rdMux = selOne  ? rdOne :
                            selFour ? (ctrlFourQ & 16'h0107) :
                            selStat ? {15'h0000, irqStatQ} :
                                      {15'h0000, irqMaskQ};

  // read data is zero outside the answer cycle, so a stale word never shows
  wire logic [31:0] rdWord = (busReq & mapped & ~wb_we_i) ? {16'h0000, rdMux} : 32'h00000000;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq & mapped;
    end
  end

  // unmapped offsets answer with an error and change nothing
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= busReq & ~mapped;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= rdWord;
    end
  end

  // ----------------------------------------
  // converter side outputs
  // ----------------------------------------
  always_comb convStart    = startConv;
  always_comb sampleActive = sampleQ;

  // channel set sampled together; sequential when simultaneous is off
  wire logic [3:0] chanMask = ~simulSample         ? 4'h1 :
                              chanCount[1]         ? 4'hF :
                              (chanCount == 2'h1)  ? 4'h3 : 4'h1;
  always_comb begin
    cfgOut.dmaEnable      = ctrlFourQ[adcsc_pkg::DMAEN_POS];
    cfgOut.wordsPerInput  = 8'h01 << ctrlFourQ[adcsc_pkg::DMABL_POS +: 3];
    cfgOut.chanSampleMask = chanMask;
    cfgOut.simultaneous   = simulSample;
  end

endmodule

// ---- tb/adcsc_trig_src.sv ----
// partner: on-chip trigger sources and the external pin
`timescale 1ns/1ps
module adcsc_trig_src (
  // clock and requests, bit 12 is the pin
  input  wire logic                 clock,
  input  wire logic [12:0]          req,
  // trigger outputs
  output adcsc_pkg::adcsc_trig_type trig,
  output logic                      extPin
);
  logic [2:0] hold_q;
  initial begin
    trig = '0;
    extPin = 1'b0;
    hold_q = '0;
  end
  always @(posedge clock) begin
    trig <= req[11:0];
    hold_q <= req[12] ? 3'h4 : hold_q - 3'(hold_q != 3'h0);
    // pin held for cycles, a one-cycle blip could die in the synchroniser
    extPin <= req[12] || hold_q > 3'h1;
  end
endmodule

// ---- tb/adcsc_top_chk.sv ----
// checker: bus, sequencing and configuration assertions
`timescale 1ns/1ps
module adcsc_top_chk #(
  parameter int CONV_CYCLES = 12,
  parameter int AUTO_CYCLES = 3
) (
  // clock and reset
  input wire logic                     clock,
  input wire logic                     rst_n,
  // watched ports
  input wire logic                     wb_stb_i,
  input wire logic                     wb_ack_o,
  input wire logic                     wb_err_o,
  input wire logic                     convStart,
  input wire logic                     sampleActive,
  input wire logic                     convDoneEvent,
  input wire adcsc_pkg::adcsc_cfg_type cfgOut,
  input wire logic                     irq
);
  localparam int DMAX = CONV_CYCLES + AUTO_CYCLES + 2;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_ANSWER: assert property ($rose(wb_stb_i) |=> wb_ack_o || wb_err_o)
    else $error("no bus answer");
  AST_START_ENDS_SAMPLE: assert property (convStart |-> sampleActive ##1 !sampleActive)
    else $error("start outside sampling");
  AST_START_PULSE: assert property (convStart |=> !convStart)
    else $error("start longer than one cycle");
  AST_DONE_BOUND: assert property (convStart |-> ##[1:DMAX] convDoneEvent)
    else $error("conversion never completed");
  AST_DONE_HOLD: assert property (convDoneEvent |-> !sampleActive && $past(convStart, CONV_CYCLES))
    else $error("done while sampling");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> wb_ack_o || $past(convDoneEvent))
    else $error("irq without cause");
  AST_WORDS: assert property ($onehot(cfgOut.wordsPerInput))
    else $error("buffer words not a power of two");
  AST_SEQ: assert property (!cfgOut.simultaneous |-> cfgOut.chanSampleMask == 4'h1)
    else $error("sequential mode mask wrong");
endmodule
bind adcsc_top adcsc_top_chk #(.CONV_CYCLES(CONV_CYCLES), .AUTO_CYCLES(AUTO_CYCLES)) u_chk (
  .clock(clock), .rst_n(rst_n), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .convStart(convStart), .sampleActive(sampleActive), .convDoneEvent(convDoneEvent),
  .cfgOut(cfgOut), .irq(irq));

// ---- tb/adcsc_top_tb.sv ----
// testbench: register, trigger and conversion scenarios
`timescale 1ns/1ps
module adcsc_top_tb;
  // ----
  // setup
  // ----
  localparam logic [3:0] C1 = adcsc_pkg::CTRL_ONE_OFS;
  localparam logic [3:0] C4 = adcsc_pkg::CTRL_FOUR_OFS;
  localparam int TBIT [16] = '{0, 12, 3, 1, 4, 2, 0, 0, 9, 10, 11, 5, 6, 7, 8, 0};
  logic                      clock, rst_n, cyc, stb, we, ack, err, gotErr, ext;
  logic                      convStart, sampleActive, convDoneEvent, irq;
  logic [3:0]                adr;
  logic [31:0]               dat, datO, q;
  logic [12:0]               req;
  adcsc_pkg::adcsc_trig_type trig;
  adcsc_pkg::adcsc_cfg_type  cfgOut;
  int                        err_count, cmp_count;
  adcsc_top #(.CONV_CYCLES(12), .AUTO_CYCLES(3)) u_dut (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
    .wb_err_o(err), .trigIn(trig), .externalInterruptPinZero(ext), .convStart(convStart),
    .sampleActive(sampleActive), .convDoneEvent(convDoneEvent), .cfgOut(cfgOut), .irq(irq));
  adcsc_trig_src u_src (.clock(clock), .req(req), .trig(trig), .extPin(ext));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = datO;
    gotErr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  // counts start and done pulses, sampled mid-cycle where combinational ones settle
  task automatic wsig(input int lim, output int s, output int d);
    s = 0;
    d = 0;
    repeat (lim) begin
      @(negedge clock);
      s += int'(convStart === 1'b1);
      d += int'(convDoneEvent === 1'b1);
    end
    @(posedge clock);
  endtask
  task automatic t_manual();
    int s, d;
    wb(adcsc_pkg::IRQ_MASK_OFS, 1'b1, 32'h1);
    chk("idle", sampleActive, 1'b0);
    wb(C1, 1'b1, 32'h2);
    chk("sample_enable", sampleActive, 1'b1);
    wb(C1, 1'b1, 32'h0);
    chk("hold", sampleActive, 1'b0);
    wsig(30, s, d);
    chk("done", d, 1);
    wb(C1, 1'b0, '0);
    chk("doneSet", q[0], 1'b1);
    chk("irq", irq, 1'b1);
    wb(C1, 1'b1, 32'h3);
    wb(C1, 1'b1, 32'h1);
    wb(C1, 1'b0, '0);
    chk("doneAtStart", q[0], 1'b0);
    wb(C1, 1'b1, 32'h0);
    wsig(30, s, d);
    chk("notDisturbed", d, 1);
    wb(C1, 1'b1, 32'h0);
    wb(C1, 1'b1, 32'h1);
    wb(C1, 1'b0, '0);
    chk("doneW1", q[0], 1'b0);
    wb(adcsc_pkg::IRQ_MASK_OFS, 1'b1, 32'h0);
    chk("masked", irq, 1'b0);
    wb(adcsc_pkg::IRQ_MASK_OFS, 1'b1, 32'h1);
    chk("unmasked", irq, 1'b1);
    wb(adcsc_pkg::IRQ_STAT_OFS, 1'b1, 32'h1);
    chk("irqClr", irq, 1'b0);
    wb(4'h2, 1'b1, '1);
    chk("unmapped", gotErr, 1'b1);
  endtask
  // wrong sources first: a swapped decode would start early
  task automatic t_trig();
    int s, d;
    for (int i = 1; i < 15; i++) begin
      if (i == 7) continue;
      wb(C1, 1'b1, 32'(i % 8) << 5 | 32'(i / 8) << 4 | 32'h2);
      req <= ~(13'h1 << TBIT[i]);
      @(posedge clock);
      req <= '0;
      repeat (6) @(posedge clock);
      chk("noStart", sampleActive, 1'b1);
      req <= 13'h1 << TBIT[i];
      @(posedge clock);
      req <= '0;
      wsig(30, s, d);
      chk("start", s, 1);
      chk("conv", d, 1);
    end
    // reserved group one code must never start a conversion
    wb(C1, 1'b1, 32'hF3);
    req <= '1;
    @(posedge clock);
    req <= '0;
    repeat (6) @(posedge clock);
    chk("reserved", sampleActive, 1'b1);
    wb(C1, 1'b1, 32'h1);
    wb(C1, 1'b1, 32'h1);
    wsig(30, s, d);
    chk("resEnd", d, 1);
  endtask
  task automatic t_auto();
    int s, d;
    wb(C1, 1'b1, 32'hE4);
    wsig(60, s, d);
    chk("autoRuns", d >= 2, 1'b1);
    wb(C1, 1'b1, 32'h3);
    wb(C1, 1'b1, 32'h0);
    wsig(40, s, d);
    chk("stopped", sampleActive, 1'b0);
  endtask
  task automatic t_cfg();
    wb(C4, 1'b0, '0);
    chk("ctl4Rst", q[15:0], adcsc_pkg::CTRL_FOUR_RST);
    for (int c = 0; c < 8; c++) begin
      wb(C4, 1'b1, 32'h100 | 32'(c));
      chk("words", cfgOut.wordsPerInput, 8'h1 << c);
      chk("dma", cfgOut.dmaEnable, 1'b1);
    end
    wb(C4, 1'b0, '0);
    chk("ctl4", q[15:0], 16'h0107);
    wb(C4, 1'b1, 32'h0);
    chk("dmaOff", cfgOut.dmaEnable, 1'b0);
    wb(C1, 1'b1, 32'h208);
    chk("mask4", cfgOut.chanSampleMask, 4'hF);
    wb(C1, 1'b1, 32'h108);
    chk("mask2", cfgOut.chanSampleMask, 4'h3);
    wb(C1, 1'b1, 32'h508);
    wb(C1, 1'b0, '0);
    chk("twelve", q[3], 1'b0);
    wb(C1, 1'b1, 32'h100);
    chk("seq", cfgOut.chanSampleMask, 4'h1);
  endtask
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, adr, dat, req} = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    wb(C1, 1'b0, '0);
    chk("ctl1Rst", q[15:0], adcsc_pkg::CTRL_ONE_RST);
    t_cfg();
    t_manual();
    t_trig();
    t_auto();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    summarize();
  end
endmodule
